// [shared/cse_pkg.sv]
package cse_pkg;

	// Clocking: system clock, internal oscillator and modulator rates
	localparam int CSE_CLK_HZ  = 100_000_000;
	localparam int CSE_OSC_HZ  = 1_000_000;
	localparam int CSE_OSC_DIV = CSE_CLK_HZ / CSE_OSC_HZ;
	localparam int CSE_MOD_DIV = 4;
	localparam int CSE_MOD_HZ  = CSE_OSC_HZ / CSE_MOD_DIV;

	// Conversion length in modulator periods, one per data rate code
	localparam int CSE_CNT_W = 15;
	localparam logic [7:0][CSE_CNT_W-1:0] CSE_RATE_LEN = {
		15'(CSE_MOD_HZ / 860),
		15'(CSE_MOD_HZ / 475),
		15'(CSE_MOD_HZ / 250),
		15'(CSE_MOD_HZ / 128),
		15'(CSE_MOD_HZ / 64),
		15'(CSE_MOD_HZ / 32),
		15'(CSE_MOD_HZ / 16),
		15'(CSE_MOD_HZ / 8)
	};

	// Register byte offsets
	localparam int          CSE_ADDR_W     = 8;
	localparam logic [7:0]  CSE_OFS_CONFIG = 8'h00;
	localparam logic [7:0]  CSE_OFS_RESULT = 8'h04;
	localparam logic [7:0]  CSE_OFS_STATUS = 8'h08;
	localparam logic [7:0]  CSE_OFS_IRQ_ST = 8'h0C;
	localparam logic [7:0]  CSE_OFS_IRQ_MK = 8'h10;

	// Configuration field positions and reset values
	localparam int          CSE_CFG_MODE   = 0;
	localparam int          CSE_CFG_REQ    = 1;
	localparam int          CSE_CFG_IN     = 2;
	localparam int          CSE_CFG_GAIN   = 5;
	localparam int          CSE_CFG_RATE   = 8;
	localparam logic        CSE_RST_MODE   = 1'b1;
	localparam logic [2:0]  CSE_RST_IN     = 3'h0;
	localparam logic [2:0]  CSE_RST_GAIN   = 3'h2;
	localparam logic [2:0]  CSE_RST_RATE   = 3'h4;

	// Status and interrupt bits
	localparam int          CSE_STS_BUSY   = 0;
	localparam int          CSE_STS_DONE   = 1;
	localparam int          CSE_IRQ_W      = 1;
	localparam int          CSE_IRQ_DONE   = 0;

	// Gain range output codes: 6.144, 4.096, 2.048, 1.024, 0.512, 0.256 V
	localparam logic [2:0]  CSE_GAIN_MAX   = 3'h5;

	// Input selector: {positive input, negative input, negative to ground}
	localparam int CSE_SE_FIRST = 4;
	localparam logic [7:0][4:0] CSE_MUX_MAP = {
		{2'h3, 2'h0, 1'b1},
		{2'h2, 2'h0, 1'b1},
		{2'h1, 2'h0, 1'b1},
		{2'h0, 2'h0, 1'b1},
		{2'h2, 2'h3, 1'b0},
		{2'h1, 2'h3, 1'b0},
		{2'h0, 2'h3, 1'b0},
		{2'h0, 2'h1, 1'b0}
	};

	typedef enum logic {CSE_DOWN, CSE_CONV} cse_fsm_t;

endpackage : cse_pkg

// [core/cse_tick_div.sv]
`timescale 1ns/1ps
`default_nettype none

module cse_tick_div
	import cse_pkg::*;
#(
	parameter int DIV = 4
)
(
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Rate enables
	input  wire logic en_in,
	output logic      tick
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} cse_div_t;

	cse_div_t s;
	cse_div_t next_s;

	always_comb
	begin
		next_s      = s;
		next_s.tick = 1'b0;
		if (en_in)
		begin
			if (s.cnt == 16'(DIV - 1))
			begin
				next_s.cnt  = 16'h0000;
				next_s.tick = 1'b1;
			end
			else
			begin
				next_s.cnt = s.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign tick = s.tick;

endmodule : cse_tick_div

`default_nettype wire

// [core/cse_sequencer.sv]
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Each single-shot request gives exactly one conversion, stored in the result register.
// - After a single-shot conversion, power down and wait for the next request.
// - In continuous mode the next conversion starts with no idle gap.
// - Continuous conversions complete at the programmed data rate.
// - A result read at any time returns the most recently completed code.
// - Selector offers four single-ended, one differential (0 against 1), and inputs 0..2 against 3.
// - A three-bit input select field in configuration picks the pairing.
// - Single-ended selections switch the negative input to ground.
// - Single-ended results are never negative codes.
// - Modulator rate is the 1 MHz oscillator divided by four.
// - A three-bit gain field selects one of six full-scale ranges.
// - Each code step equals the selected span over two to the sixteenth.
// - All conversion timing comes from the internal oscillator only.
// - Writing one to the request bit powers up, clears it, starts a conversion.
// - A request written during a conversion is ignored, neither restarting nor queued.
// - Mode bit one selects single-shot with power-down, zero selects continuous.
// - After reset, configuration takes defaults and the converter is powered down.
module cse_sequencer
	import cse_pkg::*;
#(
	parameter int OSC_DIV = CSE_OSC_DIV
)
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Interrupt
	output logic             irq,
	// Front end and digital filter
	input  wire logic [15:0] filter_code,
	output logic             modulator_enable,
	output logic             modulator_tick,
	output logic             conversion_start,
	output logic [1:0]       mux_pos_input,
	output logic [1:0]       mux_neg_input,
	output logic             neg_to_ground,
	output logic [2:0]       gain_range_select
);

	typedef struct packed {
		logic                  single_mode;
		logic                  single_req;
		logic [2:0]            in_sel;
		logic [2:0]            gain_sel;
		logic [2:0]            rate_sel;
		logic [2:0]            act_rate;
		cse_fsm_t              fsm;
		logic [CSE_CNT_W-1:0]  cnt;
		logic [15:0]           result;
		logic                  done;
		logic [CSE_IRQ_W-1:0]  irq_st;
		logic [CSE_IRQ_W-1:0]  irq_msk;
		logic                  wr_pend;
		logic                  rd_pend;
		logic [CSE_ADDR_W-1:0] ap_addr;
		logic                  ready;
		logic [31:0]           rdata;
		logic                  irq;
		logic [1:0]            mux_pos;
		logic [1:0]            mux_neg;
		logic                  neg_gnd;
		logic [2:0]            gain_out;
		logic                  mod_en;
		logic                  conv_start;
	} cse_state_t;

	cse_state_t s;
	cse_state_t next_s;

	logic osc_tick;
	logic mod_tick;
	logic take;
	logic start;
	logic conv_end;
	logic se_now;
	logic [15:0] code_adj;
	logic [31:0] read_word;

	cse_tick_div #(.DIV(OSC_DIV)) u_osc_div (
		.hclk    (hclk),
		.hresetn (hresetn),
		.en_in   (1'b1),
		.tick    (osc_tick)
	);

	cse_tick_div #(.DIV(CSE_MOD_DIV)) u_mod_div (
		.hclk    (hclk),
		.hresetn (hresetn),
		.en_in   (osc_tick),
		.tick    (mod_tick)
	);

	assign take = hsel && hready && htrans[1];

	// Single-ended selection is the one just latched for this conversion
	assign se_now = s.neg_gnd;

	assign code_adj = (se_now && filter_code[15]) ? 16'h0000 : filter_code;

	// conversion ends after the latched rate's modulator count
	assign conv_end = (s.fsm == CSE_CONV) && mod_tick && (s.cnt == CSE_RATE_LEN[s.act_rate] - 15'h0001);

	// mode selects request-driven or free-running starts
	assign start = ((s.fsm == CSE_DOWN) && (s.single_mode ? s.single_req : 1'b1))
		|| (conv_end && !s.single_mode);

	always_comb
	begin
		read_word = 32'h0000_0000;
		unique case (s.ap_addr)
			CSE_OFS_CONFIG:
			begin
				read_word[CSE_CFG_MODE]              = s.single_mode;
				read_word[CSE_CFG_REQ]               = s.single_req;
				read_word[CSE_CFG_IN +: 3]           = s.in_sel;
				read_word[CSE_CFG_GAIN +: 3]         = s.gain_sel;
				read_word[CSE_CFG_RATE +: 3]         = s.rate_sel;
			end
			CSE_OFS_RESULT: read_word[15:0] = s.result;
			CSE_OFS_STATUS:
			begin
				read_word[CSE_STS_BUSY] = (s.fsm == CSE_CONV);
				read_word[CSE_STS_DONE] = s.done;
			end
			CSE_OFS_IRQ_ST: read_word[CSE_IRQ_W-1:0] = s.irq_st;
			CSE_OFS_IRQ_MK: read_word[CSE_IRQ_W-1:0] = s.irq_msk;
			default: read_word = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		next_s            = s;
		next_s.conv_start = 1'b0;
		next_s.wr_pend    = 1'b0;

		// Address phase; reads take one wait state so data reflect prior writes
		if (take)
		begin
			next_s.ap_addr = haddr[CSE_ADDR_W-1:0];
			next_s.wr_pend = hwrite;
			next_s.rd_pend = !hwrite;
			next_s.ready   = hwrite;
		end

		if (s.rd_pend)
		begin
			next_s.rdata   = read_word;
			next_s.ready   = 1'b1;
			next_s.rd_pend = 1'b0;
			// reading the result clears the complete flag
			if (s.ap_addr == CSE_OFS_RESULT)
				next_s.done = 1'b0;
		end

		if (s.wr_pend)
		begin
			unique case (s.ap_addr)
				CSE_OFS_CONFIG:
				begin
					// input, gain and rate stored, applied only at next start; mode bit acts at once
					next_s.single_mode = hwdata[CSE_CFG_MODE];
					next_s.in_sel      = hwdata[CSE_CFG_IN +: 3];
					next_s.gain_sel    = hwdata[CSE_CFG_GAIN +: 3];
					next_s.rate_sel    = hwdata[CSE_CFG_RATE +: 3];
					if (hwdata[CSE_CFG_REQ] && hwdata[CSE_CFG_MODE] && (s.fsm == CSE_DOWN) && !start)
						next_s.single_req = 1'b1;
				end
				CSE_OFS_IRQ_ST: next_s.irq_st = s.irq_st & ~hwdata[CSE_IRQ_W-1:0];
				CSE_OFS_IRQ_MK: next_s.irq_msk = hwdata[CSE_IRQ_W-1:0];
				default: next_s.irq_msk = s.irq_msk;
			endcase
		end

		if ((s.fsm == CSE_CONV) && mod_tick)
			next_s.cnt = s.cnt + 15'h0001;

		if (conv_end)
		begin
			// filter code stored unscaled, one step per span over 2^16
			next_s.result = code_adj;
			// set wins over a same-cycle read clear
			next_s.done = 1'b1;
			next_s.irq_st[CSE_IRQ_DONE] = 1'b1;
			// single-shot powers down after one result
			if (s.single_mode)
			begin
				next_s.fsm    = CSE_DOWN;
				next_s.mod_en = 1'b0;
			end
		end

		// start latches configuration; continuous restarts on the end cycle
		if (start)
		begin
			next_s.fsm        = CSE_CONV;
			next_s.cnt        = '0;
			next_s.single_req = 1'b0;
			next_s.mod_en     = 1'b1;
			next_s.conv_start = 1'b1;
			next_s.act_rate   = s.rate_sel;
			// selector map applied at start only
			{next_s.mux_pos, next_s.mux_neg, next_s.neg_gnd} = CSE_MUX_MAP[s.in_sel];
			// unused gain codes fall to the narrowest range
			next_s.gain_out = (s.gain_sel > CSE_GAIN_MAX) ? CSE_GAIN_MAX : s.gain_sel;
		end

		next_s.irq = |(next_s.irq_st & next_s.irq_msk);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s             <= '0;
			s.fsm         <= CSE_DOWN;
			s.single_mode <= CSE_RST_MODE;
			s.in_sel      <= CSE_RST_IN;
			s.gain_sel    <= CSE_RST_GAIN;
			s.rate_sel    <= CSE_RST_RATE;
			s.gain_out    <= CSE_RST_GAIN;
			s.ready       <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign hreadyout         = s.ready;
	assign hresp             = 1'b0;
	assign hrdata            = s.rdata;
	assign irq               = s.irq;
	assign modulator_enable  = s.mod_en;
	assign modulator_tick    = mod_tick;
	assign conversion_start  = s.conv_start;
	assign mux_pos_input     = s.mux_pos;
	assign mux_neg_input     = s.mux_neg;
	assign neg_to_ground     = s.neg_gnd;
	assign gain_range_select = s.gain_out;

	// Helper: oscillator ticks seen since the previous modulator tick
	logic [3:0] osc_seen;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			osc_seen <= 4'h0;
		else if (mod_tick)
			osc_seen <= osc_tick ? 4'h1 : 4'h0;
		else if (osc_tick)
			osc_seen <= osc_seen + 4'h1;
	end

	// Helper: cycles since the last conversion end; only chained conversions start tick-aligned
	logic [31:0] end_gap;
	logic        chained;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			end_gap <= 32'h0000_0000;
			chained <= 1'b0;
		end
		else
		begin
			end_gap <= conv_end ? 32'h0000_0000 : end_gap + 32'h0000_0001;
			if (start)
				chained <= conv_end;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence seq_single_go;
		(s.fsm == CSE_DOWN) && s.single_mode && s.single_req;
	endsequence

	sequence seq_powered_up;
		(s.fsm == CSE_CONV) && !s.single_req && s.mod_en && s.conv_start;
	endsequence

	property p_single_start;
		seq_single_go |=> seq_powered_up;
	endproperty
	a_single_start: assert property (p_single_start) else $error("single request did not start");

	property p_req_ignored;
		(s.fsm == CSE_CONV) && !conv_end |=> !s.single_req;
	endproperty
	a_req_ignored: assert property (p_req_ignored) else $error("request queued during conversion");

	property p_single_stop;
		conv_end && s.single_mode |=> (s.fsm == CSE_DOWN) && !s.mod_en ##1 (s.fsm == CSE_DOWN);
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("no power-down after single shot");

	property p_cont_restart;
		conv_end && !s.single_mode |=> (s.fsm == CSE_CONV) && (s.cnt == 15'h0000) && s.conv_start;
	endproperty
	a_cont_restart: assert property (p_cont_restart) else $error("gap between continuous conversions");

	property p_result_update;
		conv_end |=> (s.result == $past(code_adj)) && s.done;
	endproperty
	a_result_update: assert property (p_result_update) else $error("result not stored");

	property p_se_clamp;
		conv_end && s.neg_gnd |=> !s.result[15];
	endproperty
	a_se_clamp: assert property (p_se_clamp) else $error("negative single-ended code");

	property p_neg_ground;
		start |=> (s.neg_gnd == ($past(s.in_sel) >= 3'(CSE_SE_FIRST)));
	endproperty
	a_neg_ground: assert property (p_neg_ground) else $error("ground switch wrong");

	property p_mod_rate;
		mod_tick |-> (osc_seen == 4'(CSE_MOD_DIV));
	endproperty
	a_mod_rate: assert property (p_mod_rate) else $error("modulator rate not osc over four");

	property p_rate_len;
		conv_end && chained |->
			(end_gap == 32'(CSE_RATE_LEN[s.act_rate]) * 32'(CSE_MOD_DIV * OSC_DIV) - 32'h0000_0001);
	endproperty
	a_rate_len: assert property (p_rate_len) else $error("conversion length wrong");

	property p_done_clear;
		s.rd_pend && (s.ap_addr == CSE_OFS_RESULT) && !conv_end |=> !s.done;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("complete flag not cleared by read");

	property p_cfg_hold;
		(s.fsm == CSE_CONV) && !start |=> $stable(s.gain_out) && $stable(s.mux_pos) && $stable(s.act_rate);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed mid conversion");

endmodule : cse_sequencer

`default_nettype wire

// [dv/cse_filter_model.sv]
`timescale 1ns/1ps
`default_nettype none

module cse_filter_model
	import cse_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Sequencer side
	input  wire logic        conversion_start,
	input  wire logic        modulator_enable,
	input  wire logic [15:0] next_code,
	output logic [15:0]      filter_code
);
	logic [15:0] held;

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			held <= 16'h0000;
		else if (conversion_start)
			held <= next_code;

	// Unpowered filter output is junk, never a stale code
	assign filter_code = modulator_enable ? held : ~held;
endmodule : cse_filter_model

`default_nettype wire

// [dv/tb_cse_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_cse_sequencer
	import cse_pkg::*;
;
	localparam int OSC = 1;
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel    = 1'b0;
	logic        hwrite  = 1'b0;
	logic [1:0]  htrans  = 2'h0;
	logic [31:0] haddr   = 32'h0;
	logic [31:0] hwdata  = 32'h0;
	logic [15:0] seed    = 16'h0;
	logic [15:0] lf      = 16'h8232;
	logic [31:0] rd;
	logic [31:0] rd_s;
	logic [31:0] cfg;
	logic        rdy_s;
	logic [15:0] exp_q[$];
	int          n_fail, tests_run, cyc, n_start, gap, last_st, n0, tick_gap, last_tick;
	wire         hreadyout, hresp, irq, modulator_enable, modulator_tick, conversion_start, neg_to_ground;
	wire [31:0]  hrdata;
	wire [15:0]  filter_code;
	wire [1:0]   mux_pos_input, mux_neg_input;
	wire [2:0]   gain_range_select;

	cse_sequencer #(.OSC_DIV(OSC)) cse_sequencer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.filter_code(filter_code), .modulator_enable(modulator_enable),
		.modulator_tick(modulator_tick), .conversion_start(conversion_start),
		.mux_pos_input(mux_pos_input), .mux_neg_input(mux_neg_input),
		.neg_to_ground(neg_to_ground), .gain_range_select(gain_range_select));

	cse_filter_model cse_filter_model_i (.hclk(hclk), .hresetn(hresetn),
		.conversion_start(conversion_start), .modulator_enable(modulator_enable),
		.next_code(seed), .filter_code(filter_code));

	always #5 hclk = ~hclk;

	// Sample at the falling edge, clear of flop updates
	always @(negedge hclk)
	begin
		rdy_s = hreadyout;
		rd_s = hrdata;
		cyc++;
		if (conversion_start === 1'b1)
		begin
			n_start++;
			gap = cyc - last_st;
			last_st = cyc;
		end
		if (modulator_tick === 1'b1)
		begin
			tick_gap = cyc - last_tick;
			last_tick = cyc;
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [4:0] mux_exp(input int s);
		if (s >= 4)
			return {2'(s - 4), 2'h0, 1'b1};
		return (s == 0) ? 5'h02 : {2'(s - 1), 2'h3, 1'b0};
	endfunction : mux_exp

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int nw;
		nw = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		do @(posedge hclk); while (rdy_s !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do
		begin
			@(posedge hclk);
			nw++;
		end
		while (rdy_s !== 1'b1);
		rd = rd_s;
		// Reads carry one wait state, writes none
		chk("wait", wr ? 1 : 2, nw);
		chk("resp", 32'h0, hresp);
	endtask : bus

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rdc

	task automatic wait_en(input logic lvl, input int n);
		int k;
		k = 0;
		while ((modulator_enable !== lvl || n_start < n) && k < 20000)
		begin
			@(negedge hclk);
			k++;
		end
	endtask : wait_en

	task automatic conclude;
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rdc("config", CSE_OFS_CONFIG, 32'h0000_0441);
		bus(1'b1, 8'h14, 32'hFFFF_FFFF);
		rdc("unmapped", 8'h14, 32'h0);
		rdc("result", CSE_OFS_RESULT, 32'h0);
		rdc("mask", CSE_OFS_IRQ_MK, 32'h0);
		chk("enable", 32'h0, modulator_enable);
		for (int i = 0; i < 8; i++)
		begin
			lf = lfsr(lf);
			// Sign alternates so ground clipping is seen both ways
			seed = {i[0], lf[14:0]};
			// Model: single-ended selections report negative codes as zero
			exp_q.push_back((i >= 4 && seed[15]) ? 16'h0000 : seed);
			cfg = {21'h0, 3'h7, 3'(i), 3'(i), 2'b01};
			bus(1'b1, CSE_OFS_IRQ_MK, {31'h0, i[0]});
			n0 = n_start;
			bus(1'b1, CSE_OFS_CONFIG, cfg | 32'h2);
			rdc("config", CSE_OFS_CONFIG, cfg);
			bus(1'b1, CSE_OFS_CONFIG, cfg | 32'h2);
			wait_en(1'b0, n0 + 1);
			chk("starts", n0 + 1, n_start);
			chk("mux", mux_exp(i), {mux_pos_input, mux_neg_input, neg_to_ground});
			chk("gain", (i > 5) ? 5 : i, gain_range_select);
			chk("irq", i[0], irq);
			rdc("status", CSE_OFS_STATUS, 32'h2);
			rdc("result", CSE_OFS_RESULT, {16'h0000, exp_q.pop_front()});
			rdc("status", CSE_OFS_STATUS, 32'h0);
			rdc("irq status", CSE_OFS_IRQ_ST, 32'h1);
			bus(1'b1, CSE_OFS_IRQ_ST, 32'h1);
			rdc("irq status", CSE_OFS_IRQ_ST, 32'h0);
			chk("irq", 32'h0, irq);
			repeat (60) @(negedge hclk);
			chk("starts", n0 + 1, n_start);
		end
		lf = lfsr(lf);
		seed = lf;
		exp_q.push_back(seed);
		n0 = n_start;
		bus(1'b1, CSE_OFS_CONFIG, 32'h0000_0704);
		wait_en(1'b1, n0 + 3);
		chk("period", 4 * OSC * (250000 / 860), gap);
		rdc("result", CSE_OFS_RESULT, {16'h0000, exp_q.pop_front()});
		chk("enable", 32'h1, modulator_enable);
		chk("tick", 4 * OSC, tick_gap);
		// New rate takes effect at the next start, so the third gap is all new rate
		n0 = n_start;
		bus(1'b1, CSE_OFS_CONFIG, 32'h0000_0604);
		wait_en(1'b1, n0 + 3);
		chk("period", 4 * OSC * (250000 / 475), gap);
		bus(1'b1, CSE_OFS_CONFIG, 32'h0000_0705);
		wait_en(1'b0, 0);
		n0 = n_start;
		repeat (60) @(negedge hclk);
		chk("starts", n0, n_start);
		conclude();
	end

	initial
	begin
		#400000;
		n_fail++;
		conclude();
	end
endmodule : tb_cse_sequencer

`default_nettype wire
